// ### bench/rcfs_core_test.sv
// Self-checking testbench of the receiver failsafe and status block
module rcfs_core_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'h0;
  logic reset_n = 1'h0;
  logic buttonPin;
  logic lowVoltagePin;
  rcfs_pkg::rcfs_frame_t frameIn;
  logic bindActive, statusLed, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [rcfs_pkg::NCH-1:0] servoOut;
  logic [rcfs_pkg::AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, st;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  int fails = 0, tests_run = 0, cycles = 0, cnt;
  localparam logic [4:0] PA = 5'h15, PB = 5'h0a;

  always #2 clk = ~clk;

  // Counts shortened so the whole run stays near ten thousand cycles
  rcfs_core #(.HOLD_CYC(32'h3e8), .FS_STOP_CYC(32'h3e8), .SHORT_MIN_CYC(32'h32), .SHORT_MAX_CYC(32'h64),
    .LIT_CYC(32'hc8), .FACTORY_CYC(32'h3e8), .FRAME_STD_CYC(32'h12c), .FRAME_FAST_CYC(32'hc8),
    .SLOW_HALF_CYC(32'h28), .FAST_HALF_CYC(32'ha), .CONFIRM_CYC(32'h64), .CONFIRM_HALF_CYC(32'ha)) DUT (
    .clk, .reset_n, .frameIn, .buttonPin, .lowVoltagePin, .bindActive, .servoOut, .statusLed,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  rcfs_link_model link (.clk(clk), .servoOut(servoOut), .frameIn(frameIn));

  // ==========================================================================
  // Timeout and verdict
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      fails++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("mismatches %0d of %0d checks", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // ==========================================================================
  // Register bus master; handshakes sampled mid-cycle, acted on at the edge
  task automatic wr(input logic [rcfs_pkg::AW-1:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw, w, b;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    b = 1'h0;
    while (!b)
    begin
      @(negedge clk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid === 1'h1;
      rsp = s_axi_bresp;
      @(posedge clk);
      if (aw)
        s_axi_awvalid <= 1'h0;
      if (w)
        s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
  endtask

  task automatic rd(input logic [rcfs_pkg::AW-1:0] a);
    logic ar, r;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    r = 1'h0;
    while (!r)
    begin
      @(negedge clk);
      ar = s_axi_arvalid && s_axi_arready;
      r = s_axi_rvalid === 1'h1;
      st = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge clk);
      if (ar)
        s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
  endtask

  task automatic chkSt(input rcfs_pkg::rcfs_state_t s);
    rd(rcfs_pkg::STATUS_OFS);
    check(32'(st[2:0]), 32'(s));
  endtask

  task automatic chkPat(input rcfs_pkg::rcfs_led_t p);
    check(32'(st[7:5]), 32'(p));
  endtask

  // One frame to settle, then one frame observed
  task automatic servoIs(input logic [4:0] exp);
    logic [4:0] m;
    repeat (300) @(posedge clk);
    link.servoMask(300, m);
    check(32'(m), 32'(exp));
  endtask

  task automatic servoCount(input int n);
    cnt = 0;
    repeat (n) @(negedge clk) cnt += (servoOut[0] === 1'h1);
  endtask

  task automatic ledCount(input int n);
    cnt = 0;
    repeat (n) @(negedge clk) cnt += (statusLed === 1'h1);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    buttonPin <= 1'h1;
    lowVoltagePin <= 1'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= 52'h0;
    repeat (11) @(posedge clk);
    @(negedge clk);
    check(32'({servoOut, statusLed, bindActive, s_axi_bvalid, s_axi_rvalid, s_axi_awready, s_axi_wready,
      s_axi_arready}), 32'h7);
    @(posedge clk);
    reset_n <= 1'h1;
  endtask

  task automatic t_bind();
    repeat (20) @(posedge clk);
    chkSt(rcfs_pkg::ST_BIND_ARM);
    buttonPin <= 1'h0;
    repeat (20) @(posedge clk);
    chkSt(rcfs_pkg::ST_BIND);
    chkPat(rcfs_pkg::PAIRING_PATTERN);
    @(negedge clk);
    check(32'(bindActive), 32'h1);
    ledCount(40);
    check(cnt, 20);
    servoIs(5'h00);
    link.sendFrame(1'h1, PA);
    chkSt(rcfs_pkg::ST_RUN);
    chkPat(rcfs_pkg::LINK_OK_PATTERN);
    check(32'(st[4]), 32'h1);
  endtask

  task automatic t_regs();
    rd(rcfs_pkg::CTRL_OFS);
    check(st, 32'(rcfs_pkg::CTRL_RST));
    wr(rcfs_pkg::CTRL_OFS, 32'h1, 4'hf);
    check(32'(rsp), 32'(rcfs_pkg::RESP_OKAY));
    rd(rcfs_pkg::CTRL_OFS);
    check(st, 32'h1);
    // A 250-cycle pulse outlasts the short frame, so fast mode keeps the line high
    repeat (300) @(posedge clk);
    servoCount(600);
    check(cnt, 600);
    wr(rcfs_pkg::CTRL_OFS, 32'h0, 4'hf);
    wr(rcfs_pkg::CTRL_OFS, 32'h1, 4'he);
    check(32'(rsp), 32'(rcfs_pkg::RESP_OKAY));
    rd(rcfs_pkg::CTRL_OFS);
    check(st, 32'h0);
    repeat (300) @(posedge clk);
    servoCount(600);
    check(cnt, 500);
    wr(rcfs_pkg::STATUS_OFS, 32'hff, 4'hf);
    check(32'(rsp), 32'(rcfs_pkg::RESP_SLVERR));
    rd(8'h08);
    check({st[29:0], rsp}, 32'(rcfs_pkg::RESP_SLVERR));
  endtask

  task automatic t_run_hold();
    servoIs(PA);
    ledCount(160);
    check(cnt, 80);
    link.sendFrame(1'h0, PB);
    chkSt(rcfs_pkg::ST_HOLD);
    check(32'(st[3]), 32'h0);
    servoIs(PA);
    repeat (1200) @(posedge clk);
    chkSt(rcfs_pkg::ST_HOLD);
    link.sendFrame(1'h1, PA);
    chkSt(rcfs_pkg::ST_RUN);
  endtask

  task automatic t_store_failsafe();
    buttonPin <= 1'h1;
    repeat (75) @(posedge clk);
    buttonPin <= 1'h0;
    repeat (5) @(posedge clk);
    chkSt(rcfs_pkg::ST_RUN);
    check(32'(st[3]), 32'h1);
    chkPat(rcfs_pkg::CONFIRM_PATTERN);
    link.sendFrame(1'h1, PB);
    link.sendFrame(1'h0, PA);
    chkSt(rcfs_pkg::ST_HOLD);
    servoIs(PB);
    repeat (500) @(posedge clk);
    chkSt(rcfs_pkg::ST_FAILSAFE);
    servoIs(PA);
    repeat (500) @(posedge clk);
    chkSt(rcfs_pkg::ST_STOPPED);
    servoIs(5'h00);
    link.sendFrame(1'h1, PB);
    chkSt(rcfs_pkg::ST_RUN);
    check(32'(st[3]), 32'h1);
    servoIs(PB);
  endtask

  task automatic t_lowv();
    lowVoltagePin <= 1'h1;
    repeat (10) @(posedge clk);
    rd(rcfs_pkg::STATUS_OFS);
    chkPat(rcfs_pkg::LOW_VOLTAGE_PATTERN);
    ledCount(100);
    check(cnt, 0);
    lowVoltagePin <= 1'h0;
    repeat (10) @(posedge clk);
  endtask

  task automatic t_factory();
    buttonPin <= 1'h1;
    repeat (100) @(negedge clk);
    check(32'(statusLed), 32'h0);
    repeat (200) @(negedge clk);
    check(32'(statusLed), 32'h1);
    repeat (800) @(negedge clk);
    check(32'(statusLed), 32'h0);
    @(posedge clk);
    buttonPin <= 1'h0;
    repeat (5) @(posedge clk);
    chkSt(rcfs_pkg::ST_NO_SIGNAL);
    chkPat(rcfs_pkg::CONFIRM_PATTERN);
    check(32'(st[4:3]), 32'h0);
    repeat (150) @(posedge clk);
    rd(rcfs_pkg::STATUS_OFS);
    chkPat(rcfs_pkg::NO_SIGNAL_PATTERN);
    ledCount(100);
    check(cnt, 100);
  endtask

  initial
  begin
    t_reset();
    t_bind();
    t_regs();
    t_run_hold();
    t_store_failsafe();
    t_lowv();
    t_factory();
    end_sim();
  end
endmodule

// ### bench/rcfs_link_model.sv
// Radio link decoder and servo channel model facing the failsafe block
module rcfs_link_model (
  input wire logic clk,
  input wire logic [rcfs_pkg::NCH-1:0] servoOut,
  output rcfs_pkg::rcfs_frame_t frameIn
);
  timeunit 1ns;
  timeprecision 1ps;

  initial frameIn = '0;

  // ==========================================================================
  // Frame source
  // Channels are scrambled after the strobe so stale widths never look valid
  task automatic sendFrame(input logic good, input logic [rcfs_pkg::NCH-1:0] pat);
    @(posedge clk);
    frameIn.valid <= 1'h1;
    frameIn.good <= good;
    for (int i = 0; i < rcfs_pkg::NCH; i++)
      frameIn.ch[i] <= pat[i] ? 12'h001 : 12'h000;
    @(posedge clk);
    frameIn.valid <= 1'h0;
    frameIn.ch <= ~frameIn.ch;
  endtask

  // ==========================================================================
  // Servo side: which channels pulsed within a window
  task automatic servoMask(input int n, output logic [rcfs_pkg::NCH-1:0] m);
    m = '0;
    repeat (n) @(negedge clk) m = m | servoOut;
  endtask
endmodule

// ### hdl/rcfs_core.sv
// Receiver hold/failsafe control, button handling, status LED and register slave
// Functional notes
// - On invalid data, keep driving servos with last valid channel values.
// - With failsafe enabled, after 0.75 s hold switch servos to presets.
// - Failsafe off at factory state and after factory reset; on at first store.
// - Short press of 0.5 to 1 s captures every channel as preset.
// - After storing presets show the confirm pattern.
// - After sixteen seconds in failsafe stop all servo pulses until signal returns.
// - Valid data again ends hold or failsafe and resumes normal output.
// - Once enabled, failsafe is only cleared by factory reset.
// - Button held ten seconds resets all settings to factory defaults.
// - Long press LED: dark at press, lit after 2 s, dark at 10 s.
// - Factory reset erases binding and presets.
// - Completed factory reset shows the confirm pattern.
// - No valid signal in normal mode gives a steady lit LED.
// - Low supply voltage keeps the LED dark.
// - Valid signal in normal mode gives slow even flashing.
// - Binding without adequate signal keeps fast flashing.
// - No servo pulses during binding.
// - Button held at power-up then released starts binding; fast then slow LED.
module rcfs_core #(
  parameter logic [31:0] HOLD_CYC = 32'(rcfs_pkg::HOLD_CYC),
  parameter logic [31:0] FS_STOP_CYC = 32'(rcfs_pkg::FS_STOP_CYC),
  parameter logic [31:0] SHORT_MIN_CYC = 32'(rcfs_pkg::SHORT_MIN_CYC),
  parameter logic [31:0] SHORT_MAX_CYC = 32'(rcfs_pkg::SHORT_MAX_CYC),
  parameter logic [31:0] LIT_CYC = 32'(rcfs_pkg::LIT_CYC),
  parameter logic [31:0] FACTORY_CYC = 32'(rcfs_pkg::FACTORY_CYC),
  parameter logic [31:0] FRAME_STD_CYC = 32'(rcfs_pkg::FRAME_STD_CYC),
  parameter logic [31:0] FRAME_FAST_CYC = 32'(rcfs_pkg::FRAME_FAST_CYC),
  parameter logic [31:0] SLOW_HALF_CYC = 32'(rcfs_pkg::SLOW_HALF_CYC),
  parameter logic [31:0] FAST_HALF_CYC = 32'(rcfs_pkg::FAST_HALF_CYC),
  parameter logic [31:0] CONFIRM_CYC = 32'(rcfs_pkg::CONFIRM_CYC),
  parameter logic [31:0] CONFIRM_HALF_CYC = 32'(rcfs_pkg::CONFIRM_HALF_CYC)
)(
  input wire logic clk,
  input wire logic reset_n,
  input wire rcfs_pkg::rcfs_frame_t frameIn,
  input wire logic buttonPin,
  input wire logic lowVoltagePin,
  output logic bindActive,
  output logic [rcfs_pkg::NCH-1:0] servoOut,
  output logic statusLed,
  input wire logic [rcfs_pkg::AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [rcfs_pkg::AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ==========================================================================
  // Functions
  function automatic logic [31:0] pulseCyc(input logic [rcfs_pkg::CW-1:0] us);
    return 32'(us) * rcfs_pkg::CYC_PER_US;
  endfunction

  function automatic logic regHit(input logic [rcfs_pkg::AW-1:0] a, input logic [rcfs_pkg::AW-1:0] ofs);
    return a[rcfs_pkg::AW-1:2] == ofs[rcfs_pkg::AW-1:2];
  endfunction

  function automatic logic [31:0] satInc(input logic [31:0] v, input logic [31:0] lim);
    return (v >= lim) ? lim : v + 32'h1;
  endfunction

  // ==========================================================================
  // Pin synchronisers
  logic btnMeta_r, btnSync_r, lowMeta_r, lowSync_r;
  always_ff @(posedge clk)
  begin
    btnMeta_r <= buttonPin;
    btnSync_r <= btnMeta_r;
    lowMeta_r <= lowVoltagePin;
    lowSync_r <= lowMeta_r;
  end

  // ==========================================================================
  // Operating state
  rcfs_pkg::rcfs_state_t state_r, stateNxt;
  logic [1:0] bootCnt_r;
  logic [31:0] stTmr_r, btnCnt_r, confirmCnt_r;
  logic fsEnable_r, bound_r, ctrlFast_r;
  logic [rcfs_pkg::CW-1:0] lastVal_r [rcfs_pkg::NCH];
  logic [rcfs_pkg::CW-1:0] preset_r [rcfs_pkg::NCH];

  wire frameGood = frameIn.valid && frameIn.good;
  wire frameBad = frameIn.valid && !frameIn.good;
  wire btnOp = (state_r != rcfs_pkg::ST_BOOT) && (state_r != rcfs_pkg::ST_BIND_ARM)
               && (state_r != rcfs_pkg::ST_BIND);
  wire facReset = btnOp && btnSync_r && (btnCnt_r == FACTORY_CYC - 32'h1);
  wire longRel = btnOp && !btnSync_r && (btnCnt_r == FACTORY_CYC);
  wire shortRel = btnOp && !btnSync_r && (btnCnt_r >= SHORT_MIN_CYC) && (btnCnt_r <= SHORT_MAX_CYC);
  // At or past the hold time, so a store made during a long hold still arms failsafe
  wire holdDone = stTmr_r >= HOLD_CYC - 32'h1;
  wire stopDone = stTmr_r == FS_STOP_CYC - 32'h1;

  always_comb
  begin
    stateNxt = state_r;
    case (state_r)
      rcfs_pkg::ST_BOOT:
        if (bootCnt_r == rcfs_pkg::BOOT_CYC)
          stateNxt = btnSync_r ? rcfs_pkg::ST_BIND_ARM : rcfs_pkg::ST_NO_SIGNAL;
      rcfs_pkg::ST_BIND_ARM:
        if (!btnSync_r)
          stateNxt = rcfs_pkg::ST_BIND;
      rcfs_pkg::ST_BIND, rcfs_pkg::ST_NO_SIGNAL, rcfs_pkg::ST_STOPPED:
        if (frameGood)
          stateNxt = rcfs_pkg::ST_RUN;
      rcfs_pkg::ST_RUN:
        if (frameBad)
          stateNxt = rcfs_pkg::ST_HOLD;
      rcfs_pkg::ST_HOLD:
        if (frameGood)
          stateNxt = rcfs_pkg::ST_RUN;
        else if (fsEnable_r && holdDone)
          stateNxt = rcfs_pkg::ST_FAILSAFE;
      rcfs_pkg::ST_FAILSAFE:
        if (frameGood)
          stateNxt = rcfs_pkg::ST_RUN;
        else if (stopDone)
          stateNxt = rcfs_pkg::ST_STOPPED;
      default:
        stateNxt = rcfs_pkg::ST_BOOT;
    endcase
    if (facReset)
      stateNxt = rcfs_pkg::ST_NO_SIGNAL;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_r <= rcfs_pkg::ST_BOOT;
      bootCnt_r <= '0;
      stTmr_r <= '0;
      btnCnt_r <= '0;
      confirmCnt_r <= '0;
    end
    else
    begin
      state_r <= stateNxt;
      bootCnt_r <= (bootCnt_r == rcfs_pkg::BOOT_CYC) ? bootCnt_r : bootCnt_r + 2'h1;
      stTmr_r <= (stateNxt != state_r) ? 32'h0 : satInc(stTmr_r, FS_STOP_CYC);
      btnCnt_r <= (btnOp && btnSync_r) ? satInc(btnCnt_r, FACTORY_CYC) : 32'h0;
      if (shortRel || longRel)
        confirmCnt_r <= CONFIRM_CYC;
      else if (confirmCnt_r != 32'h0)
        confirmCnt_r <= confirmCnt_r - 32'h1;
    end
  end

  // ==========================================================================
  // Settings: failsafe enable, binding, presets
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      fsEnable_r <= 1'b0;
      bound_r <= 1'b0;
    end
    else if (facReset)
    begin
      fsEnable_r <= 1'b0;
      bound_r <= 1'b0;
    end
    else
    begin
      if (shortRel)
        fsEnable_r <= 1'b1;
      if (state_r == rcfs_pkg::ST_BIND && frameGood)
        bound_r <= 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    for (int i = 0; i < rcfs_pkg::NCH; i++)
    begin
      if (!reset_n || facReset)
        preset_r[i] <= rcfs_pkg::PRESET_DEF;
      else if (shortRel)
        preset_r[i] <= lastVal_r[i];
      if (!reset_n)
        lastVal_r[i] <= rcfs_pkg::PRESET_DEF;
      else if (frameGood)
        lastVal_r[i] <= frameIn.ch[i];
    end
  end

  // ==========================================================================
  // Servo pulse generation
  logic [31:0] frameCnt_r;
  logic [rcfs_pkg::NCH-1:0] servoNxt;
  wire [31:0] framePeriod = ctrlFast_r ? FRAME_FAST_CYC : FRAME_STD_CYC;
  // Boot, no-signal, stopped and binding states drive no pulses at all
  wire servoDrive = (state_r == rcfs_pkg::ST_RUN) || (state_r == rcfs_pkg::ST_HOLD)
                    || (state_r == rcfs_pkg::ST_FAILSAFE);
  wire useFs = state_r == rcfs_pkg::ST_FAILSAFE;

  always_comb
  begin
    for (int i = 0; i < rcfs_pkg::NCH; i++)
      servoNxt[i] = servoDrive && (frameCnt_r < pulseCyc(useFs ? preset_r[i] : lastVal_r[i]));
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      frameCnt_r <= '0;
      servoOut <= '0;
    end
    else
    begin
      frameCnt_r <= (frameCnt_r >= framePeriod - 32'h1) ? 32'h0 : frameCnt_r + 32'h1;
      servoOut <= servoNxt;
    end
  end

  // ==========================================================================
  // Status LED
  rcfs_pkg::rcfs_led_t ledPat;
  logic [31:0] ledTmr_r;
  logic ledPh_r, ledNxt;

  always_comb
  begin
    if (lowSync_r)
      ledPat = rcfs_pkg::LOW_VOLTAGE_PATTERN;
    else if (btnOp && btnSync_r)
      ledPat = rcfs_pkg::LONG_PRESS_PATTERN;
    else if (confirmCnt_r != 32'h0)
      ledPat = rcfs_pkg::CONFIRM_PATTERN;
    else if (state_r == rcfs_pkg::ST_BIND || state_r == rcfs_pkg::ST_BIND_ARM)
      ledPat = rcfs_pkg::PAIRING_PATTERN;
    else if (state_r == rcfs_pkg::ST_RUN)
      ledPat = rcfs_pkg::LINK_OK_PATTERN;
    else
      ledPat = rcfs_pkg::NO_SIGNAL_PATTERN;
  end

  wire [31:0] ledHalf = (ledPat == rcfs_pkg::PAIRING_PATTERN) ? FAST_HALF_CYC
                      : (ledPat == rcfs_pkg::CONFIRM_PATTERN) ? CONFIRM_HALF_CYC : SLOW_HALF_CYC;
  wire ledWrap = ledTmr_r >= ledHalf - 32'h1;

  always_comb
  begin
    case (ledPat)
      rcfs_pkg::LOW_VOLTAGE_PATTERN: ledNxt = 1'b0;
      rcfs_pkg::NO_SIGNAL_PATTERN: ledNxt = 1'b1;
      rcfs_pkg::LONG_PRESS_PATTERN: ledNxt = (btnCnt_r >= LIT_CYC) && (btnCnt_r < FACTORY_CYC);
      default: ledNxt = ledPh_r;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      ledTmr_r <= '0;
      ledPh_r <= 1'b0;
      statusLed <= 1'b0;
      bindActive <= 1'b0;
    end
    else
    begin
      ledTmr_r <= ledWrap ? 32'h0 : ledTmr_r + 32'h1;
      ledPh_r <= ledWrap ? !ledPh_r : ledPh_r;
      statusLed <= ledNxt;
      bindActive <= stateNxt == rcfs_pkg::ST_BIND;
    end
  end

  // ==========================================================================
  // AXI4-Lite slave: address and data taken in either order, one word each
  logic awHeld_r, wHeld_r;
  logic [rcfs_pkg::AW-1:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  rcfs_pkg::rcfs_status_t statusWord;

  assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire awTake = s_axi_awvalid && s_axi_awready;
  wire wTake = s_axi_wvalid && s_axi_wready;
  wire arTake = s_axi_arvalid && s_axi_arready;
  wire [rcfs_pkg::AW-1:0] wrAddr = awHeld_r ? awAddr_r : s_axi_awaddr;
  wire [31:0] wrData = wHeld_r ? wData_r : s_axi_wdata;
  wire [3:0] wrStrb = wHeld_r ? wStrb_r : s_axi_wstrb;
  wire wrFire = (awHeld_r || awTake) && (wHeld_r || wTake);
  wire wrCtrlHit = regHit(wrAddr, rcfs_pkg::CTRL_OFS);
  wire rdCtrlHit = regHit(s_axi_araddr, rcfs_pkg::CTRL_OFS);
  wire rdStatHit = regHit(s_axi_araddr, rcfs_pkg::STATUS_OFS);
  assign statusWord = '{lowVoltage: lowSync_r, button: btnSync_r, pattern: ledPat,
                        bound: bound_r, fsEnabled: fsEnable_r, state: state_r};
  wire [31:0] rdWord = rdCtrlHit ? {31'h0, ctrlFast_r} : rdStatHit ? 32'(statusWord) : 32'h0;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= '0;
      wData_r <= '0;
      wStrb_r <= '0;
      ctrlFast_r <= rcfs_pkg::CTRL_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= rcfs_pkg::RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= rcfs_pkg::RESP_OKAY;
    end
    else
    begin
      if (awTake)
        awAddr_r <= s_axi_awaddr;
      if (wTake)
      begin
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      awHeld_r <= wrFire ? 1'b0 : (awHeld_r || awTake);
      wHeld_r <= wrFire ? 1'b0 : (wHeld_r || wTake);
      if (wrFire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrCtrlHit ? rcfs_pkg::RESP_OKAY : rcfs_pkg::RESP_SLVERR;
        if (wrCtrlHit && wrStrb[0])
          ctrlFast_r <= wrData[rcfs_pkg::CTRL_FAST_BIT];
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (arTake)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdWord;
        s_axi_rresp <= (rdCtrlHit || rdStatHit) ? rcfs_pkg::RESP_OKAY : rcfs_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  chk_hold_entry: assert property (state_r == rcfs_pkg::ST_RUN && frameBad && !facReset
    |=> state_r == rcfs_pkg::ST_HOLD)
    else $error("bad frame did not enter hold");
  chk_failsafe_entry: assert property (state_r == rcfs_pkg::ST_HOLD && !frameGood && !facReset
    && fsEnable_r && holdDone |=> state_r == rcfs_pkg::ST_FAILSAFE)
    else $error("hold timeout did not enter failsafe");
  chk_hold_no_fs: assert property (state_r == rcfs_pkg::ST_HOLD && !fsEnable_r
    |=> state_r != rcfs_pkg::ST_FAILSAFE)
    else $error("failsafe entered while disabled");
  chk_preset_store: assert property (shortRel |=> fsEnable_r && confirmCnt_r == CONFIRM_CYC
    && ledPat != rcfs_pkg::LONG_PRESS_PATTERN && preset_r[0] == $past(lastVal_r[0]))
    else $error("short press did not store presets");
  chk_stop_pulses: assert property (state_r == rcfs_pkg::ST_FAILSAFE && stopDone && !frameGood
    && !facReset |=> state_r == rcfs_pkg::ST_STOPPED ##1 servoOut == '0)
    else $error("failsafe did not stop pulses");
  chk_resume_run: assert property (frameGood && !facReset && (state_r == rcfs_pkg::ST_HOLD
    || state_r == rcfs_pkg::ST_FAILSAFE || state_r == rcfs_pkg::ST_STOPPED) |=> state_r == rcfs_pkg::ST_RUN)
    else $error("valid data did not resume output");
  chk_fs_sticky: assert property (fsEnable_r && !facReset |=> fsEnable_r)
    else $error("failsafe enable lost");
  chk_factory_clear: assert property (facReset |=> !fsEnable_r && !bound_r
    && preset_r[0] == rcfs_pkg::PRESET_DEF && state_r == rcfs_pkg::ST_NO_SIGNAL)
    else $error("factory reset incomplete");
  chk_bind_quiet: assert property (state_r == rcfs_pkg::ST_BIND [*2] |-> servoOut == '0)
    else $error("pulses during binding");
  chk_led_lowv: assert property (lowSync_r |=> !statusLed)
    else $error("led lit at low voltage");
  chk_led_nosig: assert property (!lowSync_r && !btnSync_r && confirmCnt_r == 32'h0
    && state_r == rcfs_pkg::ST_NO_SIGNAL |=> statusLed)
    else $error("no-signal led not steady");

  cov_failsafe: cover property (state_r == rcfs_pkg::ST_HOLD ##1 state_r == rcfs_pkg::ST_FAILSAFE);
  cov_stopped: cover property (state_r == rcfs_pkg::ST_FAILSAFE ##1 state_r == rcfs_pkg::ST_STOPPED);
  cov_store: cover property (shortRel);
  cov_factory: cover property (longRel);
endmodule

// ### inc/rcfs_pkg.sv
// Shared constants, types and register map of the receiver failsafe/status block
package rcfs_pkg;
  // ==========================================================================
  // Sizes and clock
  localparam int NCH = 5;
  localparam int CW = 12;
  localparam int AW = 8;
  localparam longint CLK_KHZ = 250000;
  localparam longint CLK_MHZ = CLK_KHZ / 1000;

  // ==========================================================================
  // Times in their own units, and derived cycle counts
  localparam longint HOLD_MS = 750;
  localparam longint FS_STOP_MS = 16000;
  localparam longint SHORT_MIN_MS = 500;
  localparam longint SHORT_MAX_MS = 1000;
  localparam longint LIT_MS = 2000;
  localparam longint FACTORY_MS = 10000;
  localparam longint FRAME_STD_US = 21000;
  localparam longint FRAME_FAST_US = 14000;
  localparam longint SLOW_HALF_MS = 500;
  localparam longint FAST_HALF_MS = 50;
  localparam longint CONFIRM_MS = 1000;
  localparam longint CONFIRM_HALF_MS = 100;
  localparam longint HOLD_CYC = HOLD_MS * CLK_KHZ;
  localparam longint FS_STOP_CYC = FS_STOP_MS * CLK_KHZ;
  localparam longint SHORT_MIN_CYC = SHORT_MIN_MS * CLK_KHZ;
  localparam longint SHORT_MAX_CYC = SHORT_MAX_MS * CLK_KHZ;
  localparam longint LIT_CYC = LIT_MS * CLK_KHZ;
  localparam longint FACTORY_CYC = FACTORY_MS * CLK_KHZ;
  localparam longint FRAME_STD_CYC = FRAME_STD_US * CLK_MHZ;
  localparam longint FRAME_FAST_CYC = FRAME_FAST_US * CLK_MHZ;
  localparam longint SLOW_HALF_CYC = SLOW_HALF_MS * CLK_KHZ;
  localparam longint FAST_HALF_CYC = FAST_HALF_MS * CLK_KHZ;
  localparam longint CONFIRM_CYC = CONFIRM_MS * CLK_KHZ;
  localparam longint CONFIRM_HALF_CYC = CONFIRM_HALF_MS * CLK_KHZ;
  localparam logic [31:0] CYC_PER_US = 32'(CLK_MHZ);
  localparam logic [1:0] BOOT_CYC = 2'h3;

  // ==========================================================================
  // Register map and reset values
  localparam logic [AW-1:0] CTRL_OFS = 8'h00;
  localparam logic [AW-1:0] STATUS_OFS = 8'h04;
  localparam int CTRL_FAST_BIT = 0;
  localparam logic CTRL_RST = 1'b0;
  localparam logic [CW-1:0] PRESET_DEF = 12'h5dc;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {ST_BOOT, ST_BIND_ARM, ST_BIND, ST_NO_SIGNAL,
                            ST_RUN, ST_HOLD, ST_FAILSAFE, ST_STOPPED} rcfs_state_t;
  typedef enum logic [2:0] {LOW_VOLTAGE_PATTERN, NO_SIGNAL_PATTERN, PAIRING_PATTERN,
                            LINK_OK_PATTERN, CONFIRM_PATTERN, LONG_PRESS_PATTERN} rcfs_led_t;
  typedef struct packed {
    logic valid;
    logic good;
    logic [NCH-1:0][CW-1:0] ch;
  } rcfs_frame_t;
  typedef struct packed {
    logic lowVoltage;
    logic button;
    rcfs_led_t pattern;
    logic bound;
    logic fsEnabled;
    rcfs_state_t state;
  } rcfs_status_t;
endpackage
